// File: spinning_motor_speed_search.sv
// speed search controller that catches a spinning motor, with register port and interrupt
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "speed_search_map.svh"

module spinning_motor_speed_search (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       ce_i,
  input  wire logic                       tick_i,
  input  wire logic [7:0]                 addr_i,
  input  wire logic [31:0]                wr_data_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic [31:0]                     rd_data_o,
  input  wire logic                       vector_mode_i,
  input  wire logic                       start_req_i,
  input  wire logic                       fault_or_coast_i,
  input  wire logic                       controlled_stop_i,
  input  wire logic                       setpoint_reverse_i,
  input  wire logic                       regen_i,
  input  wire logic [15:0]                work_volts_i,
  output var speed_search_pkg::demand_t   demand_o,
  output logic                            active_o,
  output logic [15:0]                     caught_setpoint_o,
  output logic                            caught_reverse_o,
  output logic                            caught_o,
  output logic                            ramp_from_zero_o,
  output logic                            plain_start_o,
  output logic                            irq_o
);
  import speed_search_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else if (ce_i)
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings
  ctrl_t       ctrl_q;
  logic [15:0] volts_set_q;
  logic [15:0] boost_set_q;
  logic [15:0] time_set_q;
  logic [15:0] min_speed_q;
  logic [15:0] reflux_set_q;
  logic [15:0] max_speed_q;
  logic [`SS_IRQ_W-1:0] irq_mask_q;

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q       <= '{one_way: 1'b0, trig: TRIG_ALWAYS,
                        field_oriented_catch_on: 1'b0, scalar_mode_catch_on: 1'b0};
      volts_set_q  <= `SS_RST_VOLTS;
      boost_set_q  <= `SS_RST_BOOST;
      time_set_q   <= `SS_RST_TIME;
      min_speed_q  <= `SS_RST_MIN_SPEED;
      reflux_set_q <= `SS_RST_REFLUX;
      max_speed_q  <= `SS_RST_MAX_SPEED;
      irq_mask_q   <= '0;
    end
    else if (ce_i && wr_i)
    begin
      case (addr_i)
        `SS_OFS_CTRL:      ctrl_q       <= ctrl_t'(wr_data_i[`SS_CTRL_DIR:0]);
        `SS_OFS_VOLTS:     volts_set_q  <= wr_data_i[15:0];
        `SS_OFS_BOOST:     boost_set_q  <= wr_data_i[15:0];
        `SS_OFS_TIME:      time_set_q   <= wr_data_i[15:0];
        `SS_OFS_MIN_SPEED: min_speed_q  <= wr_data_i[15:0];
        `SS_OFS_REFLUX:    reflux_set_q <= wr_data_i[15:0];
        `SS_OFS_MAX_SPEED: max_speed_q  <= wr_data_i[15:0];
        `SS_OFS_IRQ_MASK:  irq_mask_q   <= wr_data_i[`SS_IRQ_W-1:0];
        default:           ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start conditions
  logic power_up_q;
  logic uncontrolled_q;
  logic enabled;
  logic trig_ok;

  assign enabled = vector_mode_i ? ctrl_q.field_oriented_catch_on
                                 : ctrl_q.scalar_mode_catch_on;

  always_comb
  begin
    case (ctrl_q.trig)
      TRIG_ALWAYS:       trig_ok = 1'b1;
      TRIG_FAULT_OR_PWR: trig_ok = uncontrolled_q | power_up_q;
      TRIG_FAULT_ONLY:   trig_ok = uncontrolled_q;
      default:           trig_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_up_q     <= 1'b1;
      uncontrolled_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start_req_i)
        power_up_q <= 1'b0;
      if (fault_or_coast_i)
        uncontrolled_q <= 1'b1;
      else if (controlled_stop_i || start_req_i)
        uncontrolled_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sweep and reflux arithmetic
  logic [23:0] sweep_ticks;
  logic [23:0] reflux_ticks;
  logic [31:0] sweep_step;
  logic [31:0] reflux_step;
  logic [31:0] min_pct;
  logic [15:0] volts_span;

  assign sweep_ticks  = (time_set_q == 16'h0) ? 24'h1
                        : 24'(time_set_q * `SS_TICKS_PER_DS);
  assign reflux_ticks = (reflux_set_q == 16'h0) ? 24'h1
                        : 24'(reflux_set_q * `SS_TICKS_PER_DS);
  assign sweep_step   = {`SS_FULL_PCT, 16'h0} / {8'h0, sweep_ticks};
  assign volts_span   = (work_volts_i > volts_set_q) ? 16'(work_volts_i - volts_set_q) : 16'h0;
  assign reflux_step  = {volts_span, 16'h0} / {8'h0, reflux_ticks};
  // minimum speed in 0.1 Hz turned into hundredths of a percent of max speed
  assign min_pct      = (max_speed_q == 16'h0) ? 32'h0
                        : (32'(min_speed_q) * 32'(`SS_FULL_PCT)) / {16'h0, max_speed_q};

  ////////////////////////////////////////////////////////////////////////////
  // sequence
  state_t      state_q;
  logic [31:0] freq_fx_q;
  logic [31:0] volts_fx_q;
  logic        reverse_q;
  logic        second_q;
  logic        regen_prev_q;
  logic        regen_rise;
  logic        below_min;
  logic        ev_start;
  logic        ev_caught;
  logic        ev_failed;
  logic [31:0] freq_next;

  assign regen_rise = regen_i & ~regen_prev_q;
  assign freq_next  = (freq_fx_q > sweep_step) ? 32'(freq_fx_q - sweep_step) : 32'h0;
  assign below_min  = {16'h0, freq_next[31:16]} < min_pct;
  assign ev_start   = (state_q == ST_IDLE) && start_req_i && enabled && trig_ok;
  assign ev_caught  = (state_q == ST_SEARCH) && regen_rise;
  assign ev_failed  = (state_q == ST_SEARCH) && !regen_rise && tick_i && below_min
                      && (second_q || ctrl_q.one_way);

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      regen_prev_q <= 1'b0;
    else if (ce_i)
      regen_prev_q <= regen_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= ST_IDLE;
      freq_fx_q  <= '0;
      volts_fx_q <= '0;
      reverse_q  <= 1'b0;
      second_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (ev_start)
          begin
            state_q    <= ST_SEARCH;
            freq_fx_q  <= {`SS_FULL_PCT, 16'h0};
            volts_fx_q <= {volts_set_q, 16'h0};
            reverse_q  <= setpoint_reverse_i;
            second_q   <= 1'b0;
          end
        end
        ST_SEARCH:
        begin
          if (regen_rise)
            state_q <= ST_REFLUX;
          else if (tick_i)
          begin
            if (!below_min)
              freq_fx_q <= freq_next;
            else if (ev_failed)
            begin
              state_q    <= ST_IDLE;
              freq_fx_q  <= '0;
              volts_fx_q <= '0;
            end
            else
            begin
              freq_fx_q <= {`SS_FULL_PCT, 16'h0};
              reverse_q <= ~reverse_q;
              second_q  <= 1'b1;
            end
          end
        end
        ST_REFLUX:
        begin
          if (tick_i)
          begin
            if (volts_fx_q[31:16] >= work_volts_i ||
                32'(volts_fx_q + reflux_step) >= {work_volts_i, 16'h0})
            begin
              volts_fx_q <= {work_volts_i, 16'h0};
              state_q    <= ST_IDLE;
            end
            else
              volts_fx_q <= 32'(volts_fx_q + reflux_step);
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive-side outputs
  logic reflux_end;

  assign reflux_end = (state_q == ST_REFLUX) && tick_i &&
                      (volts_fx_q[31:16] >= work_volts_i ||
                       32'(volts_fx_q + reflux_step) >= {work_volts_i, 16'h0});

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      demand_o          <= '0;
      active_o          <= 1'b0;
      caught_setpoint_o <= '0;
      caught_reverse_o  <= 1'b0;
      caught_o          <= 1'b0;
      ramp_from_zero_o  <= 1'b0;
      plain_start_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      active_o         <= (state_q != ST_IDLE) ? !(ev_failed || reflux_end) : ev_start;
      ramp_from_zero_o <= ev_failed;
      plain_start_o    <= (state_q == ST_IDLE) && start_req_i && !ev_start;
      caught_o         <= reflux_end;
      demand_o.reverse <= reverse_q;
      demand_o.freq    <= freq_fx_q[31:16];
      demand_o.volts   <= (state_q == ST_IDLE) ? 16'h0 : volts_fx_q[31:16];
      demand_o.boost   <= (state_q == ST_SEARCH) ? boost_set_q : 16'h0;
      if (ev_caught)
      begin
        caught_setpoint_o <= freq_fx_q[31:16];
        caught_reverse_o  <= reverse_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  logic [`SS_IRQ_W-1:0] irq_stat_q;
  logic [`SS_IRQ_W-1:0] irq_set;
  logic [`SS_IRQ_W-1:0] irq_clr;

  assign irq_set = {ev_failed, ev_caught, ev_start};
  assign irq_clr = (wr_i && addr_i == `SS_OFS_IRQ_STATUS) ? wr_data_i[`SS_IRQ_W-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < `SS_IRQ_W; gi++)
    begin : g_irq
      always_ff @(posedge sys_clk_i or negedge rst_n)
      begin
        if (!rst_n)
          irq_stat_q[gi] <= 1'b0;
        else if (ce_i)
        begin
          // a new event beats a clear in the same cycle
          if (irq_set[gi])
            irq_stat_q[gi] <= 1'b1;
          else if (irq_clr[gi])
            irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_o <= 1'b0;
    else if (ce_i)
      irq_o <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0;
    case (addr_i)
      `SS_OFS_CTRL:       rd_mux = {27'h0, ctrl_q};
      `SS_OFS_VOLTS:      rd_mux = {16'h0, volts_set_q};
      `SS_OFS_BOOST:      rd_mux = {16'h0, boost_set_q};
      `SS_OFS_TIME:       rd_mux = {16'h0, time_set_q};
      `SS_OFS_MIN_SPEED:  rd_mux = {16'h0, min_speed_q};
      `SS_OFS_REFLUX:     rd_mux = {16'h0, reflux_set_q};
      `SS_OFS_MAX_SPEED:  rd_mux = {16'h0, max_speed_q};
      `SS_OFS_STATE:      rd_mux = {26'h0, power_up_q, uncontrolled_q, second_q,
                                    reverse_q, state_q};
      `SS_OFS_SETPOINT:   rd_mux = {15'h0, caught_reverse_o, caught_setpoint_o};
      `SS_OFS_IRQ_STATUS: rd_mux = {29'h0, irq_stat_q};
      `SS_OFS_IRQ_MASK:   rd_mux = {29'h0, irq_mask_q};
      `SS_OFS_FREQ:       rd_mux = {16'h0, freq_fx_q[31:16]};
      default:            rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_o <= '0;
    else if (ce_i)
      rd_data_o <= rd_i ? rd_mux : 32'h0;
  end

endmodule : spinning_motor_speed_search
`default_nettype wire

// File: speed_search_map.svh
// register offsets, field positions, reset values and timing counts of the speed search block
`ifndef SPEED_SEARCH_MAP_SVH
`define SPEED_SEARCH_MAP_SVH

`define SS_OFS_CTRL        8'h00
`define SS_OFS_VOLTS       8'h04
`define SS_OFS_BOOST       8'h08
`define SS_OFS_TIME        8'h0c
`define SS_OFS_MIN_SPEED   8'h10
`define SS_OFS_REFLUX      8'h14
`define SS_OFS_MAX_SPEED   8'h18
`define SS_OFS_STATE       8'h1c
`define SS_OFS_SETPOINT    8'h20
`define SS_OFS_IRQ_STATUS  8'h24
`define SS_OFS_IRQ_MASK    8'h28
`define SS_OFS_FREQ        8'h2c

`define SS_CTRL_SCALAR     0
`define SS_CTRL_FIELD      1
`define SS_CTRL_TRIG_LO    2
`define SS_CTRL_TRIG_HI    3
`define SS_CTRL_DIR        4

`define SS_IRQ_START       0
`define SS_IRQ_CAUGHT      1
`define SS_IRQ_FAILED      2
`define SS_IRQ_W           3

`define SS_RST_VOLTS       16'h0384
`define SS_RST_BOOST       16'h0fa0
`define SS_RST_TIME        16'h0032
`define SS_RST_MIN_SPEED   16'h0032
`define SS_RST_REFLUX      16'h001e
`define SS_RST_MAX_SPEED   16'h01f4

`define SS_FULL_PCT        16'h2710
`define SS_TICK_HZ         1000
`define SS_TICKS_PER_DS    (`SS_TICK_HZ / 10)

`endif

// File: speed_search_pkg.sv
// types shared by the speed search block
package speed_search_pkg;

  typedef enum logic [1:0] {
    TRIG_ALWAYS     = 2'b00,
    TRIG_FAULT_OR_PWR = 2'b01,
    TRIG_FAULT_ONLY = 2'b10
  } trig_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SEARCH = 2'b01,
    ST_REFLUX = 2'b10
  } state_t;

  typedef struct packed {
    logic  one_way;
    trig_t trig;
    logic  field_oriented_catch_on;
    logic  scalar_mode_catch_on;
  } ctrl_t;

  typedef struct packed {
    logic        reverse;
    logic [15:0] freq;
    logic [15:0] volts;
    logic [15:0] boost;
  } demand_t;

endpackage : speed_search_pkg

// File: spinning_motor_speed_search_monitor.sv
// assertion checker for the speed search block
`timescale 1ns/100ps
`default_nettype none
module speed_search_monitor (
  input wire logic                      sys_clk_i,
  input wire logic                      rstn_i,
  input wire logic                      tick_i,
  input wire logic                      rd_i,
  input wire logic [31:0]               rd_data_o,
  input wire logic                      start_req_i,
  input wire logic                      setpoint_reverse_i,
  input wire speed_search_pkg::demand_t demand_o,
  input wire logic                      active_o,
  input wire logic                      caught_o,
  input wire logic                      ramp_from_zero_o,
  input wire logic                      plain_start_o
);
  import speed_search_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_drop; ##[0:1] !active_o; endsequence
  sequence s_same_pass;
    active_o && $past(active_o) && $past(active_o, 2) && $stable(demand_o.reverse);
  endsequence
  property p_launch; $rose(active_o) |-> $past(start_req_i); endproperty
  a_launch: assert property (p_launch) else $error("active without start");
  property p_full;
    $rose(active_o) |=> demand_o.freq == 16'h2710
                        && demand_o.reverse == $past(setpoint_reverse_i, 2);
  endproperty
  a_full: assert property (p_full) else $error("search not from full speed");
  property p_down; s_same_pass |-> demand_o.freq <= $past(demand_o.freq); endproperty
  a_down: assert property (p_down) else $error("search freq rose");
  property p_step; s_same_pass and $changed(demand_o.freq) |-> $past(tick_i, 2); endproperty
  a_step: assert property (p_step) else $error("freq step without tick");
  property p_caught; caught_o |-> s_drop; endproperty
  a_caught: assert property (p_caught) else $error("active after catch");
  property p_fail; ramp_from_zero_o |-> s_drop; endproperty
  a_fail: assert property (p_fail) else $error("active after failure");
  property p_plain; plain_start_o |-> !active_o ##1 !active_o; endproperty
  a_plain: assert property (p_plain) else $error("plain start with active");
  property p_once; caught_o |=> !caught_o; endproperty
  a_once: assert property (p_once) else $error("catch pulse too long");
  property p_rd; rd_data_o != 32'h0 |-> $past(rd_i); endproperty
  a_rd: assert property (p_rd) else $error("read data without read");
endmodule : speed_search_monitor
bind spinning_motor_speed_search speed_search_monitor u_speed_search_monitor (
  .sys_clk_i, .rstn_i, .tick_i, .rd_i, .rd_data_o, .start_req_i, .setpoint_reverse_i,
  .demand_o, .active_o, .caught_o, .ramp_from_zero_o, .plain_start_o);
`default_nettype wire

// File: drive_partner_model.sv
// speed loop and power stage model: control tick, load state, working volts
`timescale 1ns/100ps
`default_nettype none
module drive_partner_model (
  input wire logic                      sys_clk_i,
  input wire logic                      rstn_i,
  input wire speed_search_pkg::demand_t demand_i,
  input wire logic [15:0]               motor_pct_i,
  input wire logic                      motor_rev_i,
  output logic                          tick_o,
  output logic                          regen_o,
  output logic [15:0]                   work_volts_o
);
  import speed_search_pkg::*;
  logic [3:0] cnt_q;
  assign work_volts_o = 16'h2710;
  always_ff @(posedge sys_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      cnt_q   <= 4'h0;
      tick_o  <= 1'b0;
      regen_o <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_q + 4'h1;
      tick_o  <= cnt_q == 4'hf;
      // energised motor regenerates once demand drops under its own speed
      regen_o <= demand_i.volts != 16'h0 && demand_i.freq < motor_pct_i
                 && demand_i.reverse == motor_rev_i;
    end
endmodule : drive_partner_model
`default_nettype wire

// File: spinning_motor_speed_search_tb.sv
// self-checking testbench for the speed search block
`timescale 1ns/100ps
`default_nettype none
`include "speed_search_map.svh"
module spinning_motor_speed_search_tb;
  import speed_search_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, tick, wr, rd, vec, start, fault, cstop, sprev;
  logic regen, active, crev, caught, rfz, plain, irq, mrev, rd_q = 1'b0, act_q = 1'b0;
  logic act_qq = 1'b0, ce = 1'b1;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, exp_rd[$], exp_ev[$];
  logic [15:0] wvolts, csp, mpct, volts_e;
  demand_t     demand;
  int          mismatches = 0, n_tests = 0;
  always #4 clk = ~clk;
  spinning_motor_speed_search u_spinning_motor_speed_search (
    .sys_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .tick_i(tick), .addr_i(addr),
    .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .vector_mode_i(vec),
    .start_req_i(start), .fault_or_coast_i(fault), .controlled_stop_i(cstop),
    .setpoint_reverse_i(sprev), .regen_i(regen), .work_volts_i(wvolts), .demand_o(demand),
    .active_o(active), .caught_setpoint_o(csp), .caught_reverse_o(crev), .caught_o(caught),
    .ramp_from_zero_o(rfz), .plain_start_o(plain), .irq_o(irq));
  drive_partner_model u_drive_partner_model (
    .sys_clk_i(clk), .rstn_i(rstn), .demand_i(demand), .motor_pct_i(mpct),
    .motor_rev_i(mrev), .tick_o(tick), .regen_o(regen), .work_volts_o(wvolts));
  ////////////////////////////////////////
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  // {controlled stop, trip, start} one-cycle pulses
  task kick(input logic [2:0] p);
    @(posedge clk);
    {cstop, fault, start} <= p;
    @(posedge clk);
    {cstop, fault, start} <= 3'h0;
  endtask : kick
  task seq(input logic [4:0] c, input logic [2:0] pre, input logic v, input logic [15:0] mp,
           input logic mr, input logic [31:0] e);
    int i;
    wr_reg(`SS_OFS_CTRL, {27'h0, c});
    vec  <= v;
    mpct <= mp;
    mrev <= mr;
    if (pre != 3'h0)
      kick(pre);
    exp_ev.push_back(e);
    kick(3'h1);
    for (i = 0; i < 20000 && exp_ev.size() != 0; i++)
      @(posedge clk);
    if (exp_ev.size() != 0)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, exp_ev.pop_front());
    end
    repeat (4) @(posedge clk);
    $display("test done ctrl=%h", c);
  endtask : seq
  ////////////////////////////////////////
  // result watcher: read data and sequence outcomes against the oldest note
  always @(posedge clk)
  begin
    if (rd_q)
      chk(rdata, exp_rd.pop_front());
    rd_q  <= rd;
    act_q  <= active;
    act_qq <= act_q;
    // demand follows the active flag by one cycle
    if (act_q && !act_qq)
    begin
      chk({16'h0, demand.volts}, {16'h0, volts_e});
      chk({16'h0, demand.boost}, 32'h0fa0);
    end
    if (caught | rfz | plain)
      chk({11'h0, crev & caught, 1'b0, plain, rfz, caught, caught ? csp : 16'h0},
          exp_ev.pop_front());
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end
  initial
  begin
    {addr, wdata, wr, rd, vec, start, fault, cstop, sprev, mpct, mrev} = '0;
    void'($urandom(5));
    volts_e = `SS_RST_VOLTS;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(`SS_OFS_CTRL, 32'h0);
    rd_reg(`SS_OFS_VOLTS, 32'h0384);
    rd_reg(`SS_OFS_BOOST, 32'h0fa0);
    rd_reg(`SS_OFS_TIME, 32'h0032);
    rd_reg(`SS_OFS_MIN_SPEED, 32'h0032);
    rd_reg(`SS_OFS_REFLUX, 32'h001e);
    rd_reg(8'h3c, 32'h0);
    volts_e = 16'(100 + $urandom % 9901);
    wr_reg(`SS_OFS_VOLTS, {16'h0, volts_e});
    wr_reg(`SS_OFS_TIME, 32'h1);
    wr_reg(`SS_OFS_REFLUX, 32'h1);
    rd_reg(`SS_OFS_VOLTS, {16'h0, volts_e});
    $display("test done registers");
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(`SS_OFS_VOLTS, 32'h0);
    ce <= 1'b1;
    rd_reg(`SS_OFS_VOLTS, {16'h0, volts_e});
    $display("test done clock enable");
    seq(5'h15, 3'h0, 1'b0, 16'h0, 1'b0, 32'h0002_0000);
    rd_reg(`SS_OFS_IRQ_STATUS, 32'h5);
    chk({31'h0, irq}, 32'h0);
    wr_reg(`SS_OFS_IRQ_MASK, 32'h7);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`SS_OFS_IRQ_STATUS, 32'h7);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test done interrupt");
    seq(5'h05, 3'h0, 1'b0, 16'h0, 1'b0, 32'h0004_0000);
    seq(5'h09, 3'h2, 1'b0, 16'd5050, 1'b0, 32'h0001_1388);
    seq(5'h05, 3'h4, 1'b0, 16'h0, 1'b0, 32'h0004_0000);
    seq(5'h09, 3'h4, 1'b0, 16'h0, 1'b0, 32'h0004_0000);
    seq(5'h0d, 3'h2, 1'b0, 16'h0, 1'b0, 32'h0004_0000);
    seq(5'h01, 3'h4, 1'b0, 16'd3050, 1'b1, 32'h0011_0bb8);
    seq(5'h11, 3'h0, 1'b0, 16'd3050, 1'b1, 32'h0002_0000);
    sprev <= 1'b1;
    seq(5'h11, 3'h0, 1'b0, 16'd6050, 1'b1, 32'h0011_1770);
    sprev <= 1'b0;
    seq(5'h01, 3'h0, 1'b1, 16'd7050, 1'b0, 32'h0004_0000);
    seq(5'h02, 3'h0, 1'b1, 16'd7050, 1'b0, 32'h0001_1b58);
    report_and_stop;
  end
endmodule : spinning_motor_speed_search_tb
`default_nettype wire
